// file: design/sca_map.vh
// Register map, field positions and reset values of the seconds counter with alarm
`ifndef SCA_MAP_VH
`define SCA_MAP_VH

// ==========================================
// Register offsets
`define SCA_ADDR_W 8
`define SCA_OFF_MODE 8'h00
`define SCA_OFF_ALARM 8'h04
`define SCA_OFF_VALUE 8'h08
`define SCA_OFF_FLAGS 8'h0C
`define SCA_OFF_IRQ_MASK 8'h10

// ==========================================
// Field positions
`define SCA_PRESCALE_MSB 15
`define SCA_PRESCALE_LSB 0
`define SCA_ALARM_IEN_BIT 16
`define SCA_TICK_IEN_BIT 17
`define SCA_RESTART_BIT 18
`define SCA_ALARM_FLAG_BIT 0
`define SCA_TICK_FLAG_BIT 1

// ==========================================
// Reset values and constants
`define SCA_PRESCALE_RESET 16'h8000
`define SCA_PRESCALE_ZERO 16'h0000
`define SCA_ALARM_RESET 32'hFFFFFFFF
`define SCA_COUNT_RESET 32'h00000000
`define SCA_COUNT_STEP 32'h00000001
`define SCA_DIV_RESET 16'h0000
`define SCA_DIV_STEP 17'h00001
`define SCA_ZERO_PERIOD 17'h10000
`define SCA_RDATA_ZERO 32'h00000000
`define SCA_SLOW_DELAY 2

`endif

// file: design/sca_sync.v
// Two-flop synchroniser with rising-edge detect for one asynchronous level
`timescale 1ns/1ps
module sca_sync (
   input wire clk,
   input wire resetn,
   input wire async_in,
   output wire level,
   output wire rise
);
   reg meta;
   reg stable;
   reg stable_d;

   // Only the second flop reads the first one
   always @(posedge clk) begin
      if (!resetn) begin
         // All high in reset, so a clock already high or low at release shows no false edge
         meta <= 1'b1;
         stable <= 1'b1;
         stable_d <= 1'b1;
      end else begin
         meta <= async_in;
         stable <= meta;
         stable_d <= stable;
      end
   end

   assign level = stable;
   assign rise = stable & ~stable_d;
endmodule

// file: design/sca_defer.v
// Delays a one-cycle request until a given number of slow-clock ticks have passed
`timescale 1ns/1ps
module sca_defer #(
   parameter DELAY = 2
) (
   input wire clk,
   input wire resetn,
   input wire req,
   input wire slow_tick,
   output wire fire
);
   reg pend;
   reg [1:0] cnt;
   wire last;

   localparam integer LAST_INT = DELAY - 1;
   localparam [1:0] LAST_CNT = LAST_INT[1:0];

   assign last = (cnt == LAST_CNT);
   assign fire = pend & slow_tick & last;

   // A request while one is pending merges into it; a request in the firing cycle re-arms
   always @(posedge clk) begin
      if (!resetn) begin
         pend <= 1'b0;
         cnt <= 2'h0;
      end else if (req && (!pend || fire)) begin
         pend <= 1'b1;
         cnt <= 2'h0;
      end else if (fire) begin
         pend <= 1'b0;
         cnt <= 2'h0;
      end else if (pend && slow_tick) begin
         cnt <= cnt + 2'h1;
      end
   end
endmodule

// file: design/sca_timer.v
// Seconds counter with alarm: register slave, slow-clock prescaler, 32-bit counter, flags, interrupt
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "sca_map.vh"
module sca_timer #(
   parameter SLOW_DELAY = `SCA_SLOW_DELAY
) (
   input wire CLK_SYS,
   input wire RESETN,
   input wire SLOW_CLK,
   input wire [`SCA_ADDR_W-1:0] REG_ADDR,
   input wire [31:0] REG_WDATA,
   input wire REG_WR,
   input wire REG_RD,
   output reg [31:0] REG_RDATA,
   output reg IRQ
);

   // ==========================================
   // Slow clock sampling
   wire slow_tick;

   // The slow clock is only ever seen through two flops, so the count, the flags
   // and every register read live in CLK_SYS alone and can never be caught mid-change
   sca_sync u_slow_sync (
      .clk(CLK_SYS),
      .resetn(RESETN),
      .async_in(SLOW_CLK),
      .level(),
      .rise(slow_tick)
   );

   // ==========================================
   // Address decode
   wire sel_mode;
   wire sel_alarm;
   wire sel_value;
   wire sel_flags;
   wire sel_mask;
   wire wr_mode;
   wire wr_alarm;
   wire wr_flags;
   wire wr_mask;
   wire rd_flags;

   assign sel_mode = (REG_ADDR == `SCA_OFF_MODE);
   assign sel_alarm = (REG_ADDR == `SCA_OFF_ALARM);
   assign sel_value = (REG_ADDR == `SCA_OFF_VALUE);
   assign sel_flags = (REG_ADDR == `SCA_OFF_FLAGS);
   assign sel_mask = (REG_ADDR == `SCA_OFF_IRQ_MASK);
   assign wr_mode = REG_WR & sel_mode;
   assign wr_alarm = REG_WR & sel_alarm;
   assign wr_flags = REG_WR & sel_flags;
   assign wr_mask = REG_WR & sel_mask;
   assign rd_flags = REG_RD & sel_flags;

   // ==========================================
   // Software registers
   reg [15:0] prescale_count;
   reg alarm_irq_enable;
   reg tick_irq_enable;
   reg [31:0] alarm_value;

   // The mask register is a second window on the two enable bits of mode
   always @(posedge CLK_SYS) begin
      if (!RESETN) begin
         prescale_count <= `SCA_PRESCALE_RESET;
         alarm_irq_enable <= 1'b0;
         tick_irq_enable <= 1'b0;
      end else if (wr_mode) begin
         prescale_count <= REG_WDATA[`SCA_PRESCALE_MSB:`SCA_PRESCALE_LSB];
         alarm_irq_enable <= REG_WDATA[`SCA_ALARM_IEN_BIT];
         tick_irq_enable <= REG_WDATA[`SCA_TICK_IEN_BIT];
      end else if (wr_mask) begin
         alarm_irq_enable <= REG_WDATA[`SCA_ALARM_FLAG_BIT];
         tick_irq_enable <= REG_WDATA[`SCA_TICK_FLAG_BIT];
      end
   end

   always @(posedge CLK_SYS) begin
      if (!RESETN) begin
         alarm_value <= `SCA_ALARM_RESET;
      end else if (wr_alarm) begin
         alarm_value <= REG_WDATA;
      end
   end

   // ==========================================
   // Deferred actions
   wire restart_req;
   wire alarm_clr_req;
   wire tick_clr_req;
   wire restart_now;
   wire alarm_clr_now;
   wire tick_clr_now;

   assign restart_req = wr_mode & REG_WDATA[`SCA_RESTART_BIT];
   // Status read clears both; a write of one clears the chosen bits the same slow way
   assign alarm_clr_req = rd_flags | (wr_flags & REG_WDATA[`SCA_ALARM_FLAG_BIT]);
   assign tick_clr_req = rd_flags | (wr_flags & REG_WDATA[`SCA_TICK_FLAG_BIT]);

   // Requests are held until the second slow tick after the access, as a true two-domain
   // timer would behave; an event in that gap is lost if the clear lands after it
   sca_defer #(.DELAY(SLOW_DELAY)) u_restart_defer (
      .clk(CLK_SYS),
      .resetn(RESETN),
      .req(restart_req),
      .slow_tick(slow_tick),
      .fire(restart_now)
   );

   sca_defer #(.DELAY(SLOW_DELAY)) u_alarm_clr_defer (
      .clk(CLK_SYS),
      .resetn(RESETN),
      .req(alarm_clr_req),
      .slow_tick(slow_tick),
      .fire(alarm_clr_now)
   );

   sca_defer #(.DELAY(SLOW_DELAY)) u_tick_clr_defer (
      .clk(CLK_SYS),
      .resetn(RESETN),
      .req(tick_clr_req),
      .slow_tick(slow_tick),
      .fire(tick_clr_now)
   );

   // ==========================================
   // Prescaler
   reg [15:0] div_cnt;
   wire [16:0] period;
   wire [16:0] div_plus;
   wire div_last;
   wire inc;

   assign period = (prescale_count == `SCA_PRESCALE_ZERO) ? `SCA_ZERO_PERIOD : {1'b0, prescale_count};
   assign div_plus = {1'b0, div_cnt} + `SCA_DIV_STEP;
   // Greater-or-equal so a smaller period written mid-count ends the current one at the next slow tick
   assign div_last = (div_plus >= period);
   assign inc = slow_tick & div_last & ~restart_now;

   always @(posedge CLK_SYS) begin
      if (!RESETN) begin
         div_cnt <= `SCA_DIV_RESET;
      end else if (restart_now) begin
         div_cnt <= `SCA_DIV_RESET;
      end else if (slow_tick) begin
         if (div_last) begin
            div_cnt <= `SCA_DIV_RESET;
         end else begin
            div_cnt <= div_plus[15:0];
         end
      end
   end

   // ==========================================
   // Counter and alarm compare
   reg [31:0] current_count;
   wire [31:0] next_count;
   wire [31:0] alarm_target;
   wire alarm_hit;

   assign next_count = current_count + `SCA_COUNT_STEP;
   assign alarm_target = alarm_value + `SCA_COUNT_STEP;
   assign alarm_hit = inc & (next_count == alarm_target);

   always @(posedge CLK_SYS) begin
      if (!RESETN) begin
         current_count <= `SCA_COUNT_RESET;
      end else if (restart_now) begin
         current_count <= `SCA_COUNT_RESET;
      end else if (inc) begin
         current_count <= next_count;
      end
   end

   // ==========================================
   // Sticky flags
   reg alarm_flag;
   reg tick_flag;

   // A set in the same cycle as the deferred clear wins
   always @(posedge CLK_SYS) begin
      if (!RESETN) begin
         alarm_flag <= 1'b0;
         tick_flag <= 1'b0;
      end else begin
         if (alarm_hit) begin
            alarm_flag <= 1'b1;
         end else if (alarm_clr_now) begin
            alarm_flag <= 1'b0;
         end
         if (inc) begin
            tick_flag <= 1'b1;
         end else if (tick_clr_now) begin
            tick_flag <= 1'b0;
         end
      end
   end

   // ==========================================
   // Interrupt
   wire next_irq;

   assign next_irq = (alarm_flag & alarm_irq_enable) | (tick_flag & tick_irq_enable);

   always @(posedge CLK_SYS) begin
      if (!RESETN) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= next_irq;
      end
   end

   // ==========================================
   // Read data
   reg [31:0] next_rdata;

   always @* begin
      next_rdata = `SCA_RDATA_ZERO;
      if (sel_mode) begin
         next_rdata[`SCA_PRESCALE_MSB:`SCA_PRESCALE_LSB] = prescale_count;
         next_rdata[`SCA_ALARM_IEN_BIT] = alarm_irq_enable;
         next_rdata[`SCA_TICK_IEN_BIT] = tick_irq_enable;
      end else if (sel_alarm) begin
         next_rdata = alarm_value;
      end else if (sel_value) begin
         next_rdata = current_count;
      end else if (sel_flags) begin
         next_rdata[`SCA_ALARM_FLAG_BIT] = alarm_flag;
         next_rdata[`SCA_TICK_FLAG_BIT] = tick_flag;
      end else if (sel_mask) begin
         next_rdata[`SCA_ALARM_FLAG_BIT] = alarm_irq_enable;
         next_rdata[`SCA_TICK_FLAG_BIT] = tick_irq_enable;
      end
   end

   // Data only in the cycle after a read; zero otherwise and for unmapped addresses
   always @(posedge CLK_SYS) begin
      if (!RESETN) begin
         REG_RDATA <= `SCA_RDATA_ZERO;
      end else if (REG_RD) begin
         REG_RDATA <= next_rdata;
      end else begin
         REG_RDATA <= `SCA_RDATA_ZERO;
      end
   end

endmodule

// file: tb/sca_timer_chk.sv
// Port-level assertions for the seconds counter with alarm
`timescale 1ns/1ps
`include "sca_map.vh"
module sca_timer_chk (
   input wire CLK_SYS,
   input wire RESETN,
   input wire SLOW_CLK,
   input wire [`SCA_ADDR_W-1:0] REG_ADDR,
   input wire [31:0] REG_WDATA,
   input wire REG_WR,
   input wire REG_RD,
   input wire [31:0] REG_RDATA,
   input wire IRQ
);
   // ==========================================
   // Shadow settings and pending deferred requests
   logic [17:0] mode_sh;
   logic [31:0] alarm_sh;
   logic slow_q;
   logic [1:0] pend;
   wire sts_rd = REG_RD && REG_ADDR == 8'h0C;
   wire val_rd = REG_RD && REG_ADDR == 8'h08;
   wire mapped = REG_ADDR inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
   always @(posedge CLK_SYS) begin
      slow_q <= SLOW_CLK;
      if (!RESETN) begin
         mode_sh <= 18'h08000;
         alarm_sh <= 32'hFFFFFFFF;
         pend <= 2'h0;
      end else begin
         if (REG_WR && REG_ADDR == 8'h00) mode_sh <= REG_WDATA[17:0];
         if (REG_WR && REG_ADDR == 8'h10) mode_sh[17:16] <= REG_WDATA[1:0];
         if (REG_WR && REG_ADDR == 8'h04) alarm_sh <= REG_WDATA;
         // Three pin edges surely cover two synchronised slow ticks, whatever the phase
         if (sts_rd || (REG_WR && REG_ADDR != 8'h04)) pend <= 2'h3;
         else if (SLOW_CLK && !slow_q && pend != 2'h0) pend <= pend - 2'h1;
      end
   end
   // ==========================================
   // Assertions
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   chk_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 32'h0)
      else $error("read data not zero outside a read answer");
   chk_mode_read: assert property (REG_RD && REG_ADDR == 8'h00 |=> REG_RDATA == {14'h0, mode_sh})
      else $error("mode read differs from written settings");
   chk_alarm_read: assert property (REG_RD && REG_ADDR == 8'h04 |=> REG_RDATA == alarm_sh)
      else $error("alarm read differs from written value");
   chk_unmapped_zero: assert property (REG_RD && !mapped |=> REG_RDATA == 32'h0)
      else $error("unmapped read not zero");
   chk_flags_upper: assert property (sts_rd |=> REG_RDATA[31:2] == 30'h0)
      else $error("reserved flag bits not zero");
   chk_irq_gated: assert property (mode_sh[17:16] == 2'h0 |=> !IRQ)
      else $error("interrupt high with both enables clear");
   chk_irq_cause: assert property ($rose(IRQ) |-> $past(mode_sh[17:16]) != 2'h0)
      else $error("interrupt rose without an enable");
   chk_clear_late: assert property ((sts_rd && IRQ && pend == 2'h0 && $stable(mode_sh)) ##1 !REG_WR [*3] |=> IRQ)
      else $error("flag clear took effect too early");
   chk_value_step: assert property ((val_rd && pend == 2'h0) ##2 val_rd |=> (REG_RDATA - $past(REG_RDATA, 2)) <= 32'h1)
      else $error("counter moved by more than one step");
   cov_alarm_irq: cover property ($rose(IRQ) && mode_sh[16]);
   cov_status_clear: cover property (sts_rd && IRQ);
   cov_value_pair: cover property (val_rd ##2 val_rd);
endmodule

bind sca_timer sca_timer_chk chk_u (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .SLOW_CLK(SLOW_CLK), .REG_ADDR(REG_ADDR),
   .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ(IRQ));

// file: tb/sca_timer_tb.sv
// Self-checking testbench for the seconds counter with alarm
`timescale 1ns/1ps
module sca_timer_tb;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic slow_clk = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic [31:0] reg_rdata;
   logic irq;
   logic [2:0] slow_div = 3'h0;
   logic [31:0] v0;
   logic [31:0] v1;
   int fails = 0;
   int checks = 0;
   int n;
   always #4 clk_sys = ~clk_sys;
   // Slow clock at one eighth of the system clock, well inside the synchroniser limit
   always @(posedge clk_sys) begin
      slow_div <= slow_div + 3'h1;
      slow_clk <= slow_div[2];
   end
   sca_timer dut_u (.CLK_SYS(clk_sys), .RESETN(resetn), .SLOW_CLK(slow_clk), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IRQ(irq));
   // ==========================================
   // Shared tasks
   task automatic summarize;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic check_val(input string what, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   // Answer is taken before this edge's updates land, so it is the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      d = reg_rdata;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
      logic [31:0] d;
      rd(a, d);
      check_val(what, e, d);
   endtask
   task automatic wait_irq(input logic lvl, input int lim);
      n = 0;
      while (irq !== lvl) begin
         @(posedge clk_sys);
         n++;
         if (n > lim) begin
            check_val("irq wait", {31'h0, lvl}, {31'h0, irq});
            summarize();
         end
      end
   endtask
   // ==========================================
   // Scenarios
   task automatic t_reset;
      rd_chk(8'h00, 32'h00008000, "mode reset");
      rd_chk(8'h04, 32'hFFFFFFFF, "alarm reset");
      rd_chk(8'h08, 32'h0, "count reset");
      rd_chk(8'h0C, 32'h0, "flags reset");
      wr(8'h14, 32'hFFFFFFFF);
      rd_chk(8'h14, 32'h0, "unmapped");
      check_val("irq reset", 32'h0, {31'h0, irq});
   endtask
   task automatic t_count;
      wr(8'h04, 32'h12345678);
      rd_chk(8'h04, 32'h12345678, "alarm");
      wr(8'h00, 32'h00040003);
      rd_chk(8'h00, 32'h00000003, "mode");
      repeat (60) @(posedge clk_sys);
      rd(8'h08, v0);
      rd(8'h08, v1);
      repeat (188) @(posedge clk_sys);
      rd(8'h08, v1);
      check_val("count step", v0 + 32'h8, v1);
      rd_chk(8'h0C, 32'h2, "tick flag");
   endtask
   task automatic t_zero;
      wr(8'h00, 32'h00040000);
      wr(8'h08, 32'hFFFFFFFF);
      repeat (40) @(posedge clk_sys);
      rd_chk(8'h08, 32'h0, "restart count");
      repeat (320) @(posedge clk_sys);
      rd_chk(8'h08, 32'h0, "zero prescale");
   endtask
   task automatic t_alarm;
      wr(8'h04, 32'h4);
      wr(8'h00, 32'h00040001);
      repeat (120) @(posedge clk_sys);
      check_val("irq masked", 32'h0, {31'h0, irq});
      wr(8'h00, 32'h00010001);
      repeat (2) @(posedge clk_sys);
      check_val("irq alarm", 32'h1, {31'h0, irq});
      repeat (40) @(posedge clk_sys);
      rd_chk(8'h0C, 32'h3, "flags");
      check_val("irq after read", 32'h1, {31'h0, irq});
      wait_irq(1'b0, 40);
      wr(8'h00, 32'h00050001);
      wait_irq(1'b1, 200);
      rd_chk(8'h08, 32'h5, "alarm count");
   endtask
   task automatic t_tick;
      rd_chk(8'h0C, 32'h3, "flags again");
      wr(8'h00, 32'h00020001);
      wait_irq(1'b1, 40);
      wr(8'h00, 32'h00000001);
      repeat (2) @(posedge clk_sys);
      check_val("irq tick off", 32'h0, {31'h0, irq});
   endtask
   // Mask window alias and write-one-to-clear of a single flag
   task automatic t_mask;
      wr(8'h10, 32'h00000002);
      rd_chk(8'h10, 32'h00000002, "mask alias");
      rd_chk(8'h00, 32'h00020001, "mode alias");
      wait_irq(1'b1, 40);
      wr(8'h00, 32'h00020000);
      repeat (40) @(posedge clk_sys);
      wr(8'h0C, 32'h00000002);
      wait_irq(1'b0, 40);
      rd_chk(8'h0C, 32'h00000000, "flags cleared");
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      t_reset();
      t_count();
      t_zero();
      t_alarm();
      t_tick();
      t_mask();
      summarize();
   end
endmodule
